// File: pcr_regs.svh
`ifndef PCR_REGS_SVH
`define PCR_REGS_SVH

// register offsets, byte addresses
`define PCR_ADDR_CTRL          4'h0
`define PCR_ADDR_STATUS        4'h4
`define PCR_ADDR_MVID          4'h8
`define PCR_ADDR_STEP          4'hc
// control and status fields
`define PCR_CTRL_LOOP_EN       0
`define PCR_CTRL_RESYNC        1
`define PCR_ST_LOCK            0
`define PCR_ST_PLL_LOCK        1
`define PCR_ST_RUNNING         2
`define PCR_ST_RESET_OUT       3
`define PCR_ST_FILL_LSB        8
`define PCR_ST_RXW_LSB         16
// link rate codes
`define PCR_RATE_LOW           2'h0
`define PCR_RATE_HIGH          2'h1
`define PCR_RATE_HIGH2         2'h2
`define PCR_RATE_RSVD          2'h3
// symbol clock per rate in MHz and symbol width
`define PCR_SYM_MHZ_LOW        162
`define PCR_SYM_MHZ_HIGH       270
`define PCR_SYM_MHZ_HIGH2      540
`define PCR_SYMBOL_BITS        10
// clock synthesis
`define PCR_FIXED_NVID_VAL     32'h0000_8000
`define PCR_FIXED_NVID_SHIFT   15
`define PCR_NCO_W              24
`define PCR_NCO_TOGGLES        4
`define PCR_MHZ_NS_SCALE       1000
`define PCR_LOOP_CYCLES        2048
`define PCR_TRIM_MAX           16'sh0100
// reconfiguration controller
`define PCR_RC_STEP            2'h0
`define PCR_RC_START           2'h1
`define PCR_RC_GO              32'h0000_0001
`define PCR_RC_BITS            6'h20
`define PCR_DIV_LAST           6'h3f
`endif

// File: pcr_pkg.sv
package pcr_pkg;

    // stream attributes as handed over by the sink
    typedef struct packed {
        logic [23:0] mvid;
        logic [23:0] nvid;
        logic [15:0] htotal;
        logic [15:0] vtotal;
        logic [15:0] hstart;
        logic [15:0] vstart;
        logic [15:0] hwidth;
        logic [15:0] vheight;
        logic        hsync_low;
        logic [14:0] hsw;
        logic        vsync_low;
        logic [14:0] vsw;
        logic        interlaced;
        logic [39:0] spare;
    } pcr_msa_t;

    // rebuilt video timing
    typedef struct packed {
        logic hsync;
        logic vsync;
        logic data_enable_out;
        logic second_field_flag;
    } pcr_sync_t;

    // register port request
    typedef struct packed {
        logic [3:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } pcr_reg_req_t;

    // clock configuration sequence
    typedef enum logic [4:0] {
        PCR_CFG_IDLE  = 5'h01,
        PCR_CFG_DIV   = 5'h02,
        PCR_CFG_BUSW  = 5'h04,
        PCR_CFG_SER   = 5'h08,
        PCR_CFG_APPLY = 5'h10
    } pcr_cfg_e;

endpackage : pcr_pkg

// File: pcr_fifo.sv
`timescale 1ns/1ps

module pcr_fifo #(
    parameter int W  = 192,
    parameter int AW = 4
) (
    // clock and reset
    input  wire logic          clk,
    input  wire logic          rstn,
    // fill side
    input  wire logic          wr_en,
    input  wire logic [W-1:0]  wr_data,
    // drain side
    input  wire logic          rd_en,
    output logic [W-1:0]       rd_data,
    output logic [AW:0]        fill
);

    localparam logic [AW:0] FULL = (AW+1)'(1) << AW;

    typedef struct packed {
        logic [(1<<AW)-1:0][W-1:0] mem;
        logic [AW-1:0]             wp;
        logic [AW-1:0]             rp;
        logic [AW:0]               cnt;
        logic [W-1:0]              rd;
    } pcr_fifo_st_t;

    pcr_fifo_st_t q;
    pcr_fifo_st_t n;
    logic         do_wr;
    logic         do_rd;

    // full refuses writes, empty repeats the last word
    always_comb
    begin
        n = q;
        do_wr = wr_en && (q.cnt != FULL);
        do_rd = rd_en && (q.cnt != '0);
        if (do_wr)
        begin
            n.mem[q.wp] = wr_data;
            n.wp = q.wp + 1'b1;
        end
        if (do_rd)
        begin
            n.rd = q.mem[q.rp];
            n.rp = q.rp + 1'b1;
        end
        n.cnt = q.cnt + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    end

    // state register
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            q <= '0;
        else
            q <= n;
    end

    assign rd_data = q.rd;
    assign fill    = q.cnt;

endmodule : pcr_fifo

// File: pcr_core.sv
// Decided for this implementation: the register offsets and the strobed register port.
`timescale 1ns/1ps
`include "pcr_regs.svh"

module pcr_core #(
    parameter int SYMBOLS_PER_CLOCK       = 4,
    parameter int CONTROL_CLOCK_PERIOD_NS = 10,
    parameter bit FIXED_NVID              = 1'b0,
    parameter int PIXELS_PER_CLOCK        = 4,
    parameter int BPP                     = 48,
    parameter int FIFO_AW                 = 4,
    parameter int LOOP_CYCLES             = `PCR_LOOP_CYCLES
) (
    // clock and reset
    input  wire logic                              clk,
    input  wire logic                              rstn,
    // register port
    input  wire pcr_pkg::pcr_reg_req_t             reg_req,
    output logic [31:0]                            reg_rdata,
    // sink side, all asynchronous to clk
    input  wire logic                              sink_video_clock_pin,
    input  wire logic [BPP*PIXELS_PER_CLOCK-1:0]   sink_video_data,
    input  wire logic                              sink_video_valid,
    input  wire logic                              sink_video_lock_in,
    input  wire logic [1:0]                        sink_link_rate,
    input  wire pcr_pkg::pcr_msa_t                 sink_msa,
    // recovered video
    output logic                                   recovered_pixel_clock,
    output logic                                   recovered_pixel_clock_double,
    output logic [BPP*PIXELS_PER_CLOCK-1:0]        vidout,
    output pcr_pkg::pcr_sync_t                     video_sync,
    output logic                                   reset_out,
    output logic                                   sink_video_lock_status
);

    localparam int DW  = BPP * PIXELS_PER_CLOCK;
    localparam int NW  = `PCR_NCO_W;
    localparam int FW  = FIFO_AW + 1;
    localparam int RXW = `PCR_SYMBOL_BITS * SYMBOLS_PER_CLOCK;
    localparam logic [FW-1:0]  FILL_MID = FW'(1) << (FIFO_AW - 1);
    localparam logic [15:0]    LOOP_LAST = 16'(LOOP_CYCLES - 1);
    localparam logic [NW-1:0]  STEP_MAX = NW'(1) << (NW - 1);
    // nco step per unit Mvid/Nvid, scaled by control period and pixels per clock
    localparam logic [63:0] K_DEN  = 64'(`PCR_MHZ_NS_SCALE) * 64'(PIXELS_PER_CLOCK);
    localparam logic [63:0] K_BASE = (64'(CONTROL_CLOCK_PERIOD_NS) * 64'(`PCR_NCO_TOGGLES)) << NW;
    localparam logic [63:0] K_LOW  = K_BASE * 64'(`PCR_SYM_MHZ_LOW) / K_DEN;
    localparam logic [63:0] K_HI   = K_BASE * 64'(`PCR_SYM_MHZ_HIGH) / K_DEN;
    localparam logic [63:0] K_HI2  = K_BASE * 64'(`PCR_SYM_MHZ_HIGH2) / K_DEN;

    typedef struct packed {
        logic [2:0]              pin;
        logic [2:0][DW-1:0]      dat;
        logic [2:0]              val;
        logic [1:0]              lck;
        logic [1:0][1:0]         rte;
        pcr_pkg::pcr_msa_t [1:0] msa;
        logic                    lock_ok;
        logic [1:0]              rate;
        logic [31:0]             nvid;
        pcr_pkg::pcr_msa_t       cfg;
        pcr_pkg::pcr_cfg_e       fsm;
        logic                    recalc;
        logic [63:0]             num;
        logic [32:0]             rem;
        logic [5:0]              cnt;
        logic                    bus_idx;
        logic                    bus_wr;
        logic [1:0]              bus_addr;
        logic [31:0]             bus_wdata;
        logic [31:0]             rc_step;
        logic [31:0]             ser_sh;
        logic [5:0]              ser_cnt;
        logic [31:0]             pll_sh;
        logic [NW-1:0]           step;
        logic [NW-1:0]           phase;
        logic                    clk2;
        logic                    rclk;
        logic signed [15:0]      trim;
        logic [15:0]             loop_cnt;
        logic [23:0]             mvid_adj;
        logic                    loop_en;
        logic                    pll_lock;
        logic                    running;
        logic [15:0]             hcnt;
        logic [15:0]             vcnt;
        pcr_pkg::pcr_sync_t      sync;
        logic                    rd_pend;
        logic [DW-1:0]           vid;
        logic                    rst_out;
        logic [31:0]             rdata;
    } pcr_core_st_t;

    pcr_core_st_t        q;
    pcr_core_st_t        n;
    logic                lock_ok;
    logic                wr_en;
    logic                rd_en;
    logic [DW-1:0]       rd_data;
    logic [FW-1:0]       fill;
    logic [NW:0]         nco_sum;
    logic                tick;
    logic signed [25:0]  adj_sum;
    logic [23:0]         adj;
    logic [63:0]         k_sel;
    logic [63:0]         prod;
    logic [32:0]         rem_try;
    logic                div_ge;
    logic [NW-1:0]       step_clamp;
    logic [15:0]         hn;
    logic [15:0]         vn;
    logic                fld;
    logic                de_n;

    // pixel store between sink clock and recovered clock
    pcr_fifo #(
        .W  (DW),
        .AW (FIFO_AW)
    ) u_fifo (
        .clk     (clk),
        .rstn    (rstn),
        .wr_en   (wr_en),
        .wr_data (q.dat[2]),
        .rd_en   (rd_en),
        .rd_data (rd_data),
        .fill    (fill)
    );

    // all next-state logic
    always_comb
    begin
        n = q;
        hn = q.hcnt;
        vn = q.vcnt;
        fld = q.sync.second_field_flag;
        de_n = 1'b0;
        rd_en = 1'b0;
        // two-flop synchronisers; data keeps a third stage to pair with the pre-edge sample
        n.pin = {q.pin[1:0], sink_video_clock_pin};
        n.dat = {q.dat[1:0], sink_video_data};
        n.val = {q.val[1:0], sink_video_valid};
        n.lck = {q.lck[0], sink_video_lock_in};
        n.rte = {q.rte[0], sink_link_rate};
        n.msa = {q.msa[0], sink_msa};
        lock_ok = q.lck[1] && (q.rte[1] != `PCR_RATE_RSVD);
        n.lock_ok = lock_ok;
        // take the word that stood before the sink clock rose
        wr_en = q.pin[1] && !q.pin[2] && q.val[2] && lock_ok;

        // numerically controlled oscillator standing in for the fractional pll
        nco_sum = {1'b0, q.phase} + {1'b0, q.step};
        n.phase = nco_sum[NW-1:0];
        tick = nco_sum[NW] && !q.clk2 && !q.rclk;
        if (nco_sum[NW])
            n.clk2 = !q.clk2;
        if (nco_sum[NW] && !q.clk2)
            n.rclk = !q.rclk;

        // adjusted Mvid and per-rate scale
        adj_sum = $signed({2'b00, q.msa[1].mvid}) + 26'(q.trim);
        if (adj_sum <= 26'sd0)
            adj = 24'h00_0001;
        else if (adj_sum[24])
            adj = 24'hff_ffff;
        else
            adj = adj_sum[23:0];
        k_sel = (q.rte[1] == `PCR_RATE_HIGH2) ? K_HI2 :
                (q.rte[1] == `PCR_RATE_HIGH)  ? K_HI : K_LOW;
        prod = 64'(adj) * k_sel;
        rem_try = {q.rem[31:0], q.num[63]};
        div_ge = rem_try >= {1'b0, q.nvid};
        step_clamp = (q.num > 64'(STEP_MAX)) ? STEP_MAX : q.num[NW-1:0];

        // configuration sequence: calculate, write over bus, serialise, apply
        n.bus_wr = 1'b0;
        unique case (q.fsm)
            pcr_pkg::PCR_CFG_IDLE:
            begin
                // lock from the sink alone starts it, software is not needed
                if (q.recalc && lock_ok)
                begin
                    n.recalc = 1'b0;
                    n.cfg = q.msa[1];
                    n.rate = q.rte[1];
                    n.nvid = FIXED_NVID ? `PCR_FIXED_NVID_VAL : 32'(q.msa[1].nvid);
                    n.mvid_adj = adj;
                    n.num = FIXED_NVID ? (prod >> `PCR_FIXED_NVID_SHIFT) : prod;
                    n.rem = '0;
                    n.cnt = '0;
                    n.fsm = FIXED_NVID ? pcr_pkg::PCR_CFG_BUSW : pcr_pkg::PCR_CFG_DIV;
                end
            end
            pcr_pkg::PCR_CFG_DIV:
            begin
                // restoring division by Nvid, one quotient bit per cycle
                n.rem = div_ge ? (rem_try - {1'b0, q.nvid}) : rem_try;
                n.num = {q.num[62:0], div_ge};
                n.cnt = q.cnt + 6'h01;
                if (q.cnt == `PCR_DIV_LAST)
                    n.fsm = pcr_pkg::PCR_CFG_BUSW;
            end
            pcr_pkg::PCR_CFG_BUSW:
            begin
                // step word first, then the start word
                n.bus_wr = 1'b1;
                n.bus_addr = q.bus_idx ? `PCR_RC_START : `PCR_RC_STEP;
                n.bus_wdata = q.bus_idx ? `PCR_RC_GO : 32'(step_clamp);
                n.bus_idx = !q.bus_idx;
                if (q.bus_idx)
                    n.fsm = pcr_pkg::PCR_CFG_SER;
            end
            pcr_pkg::PCR_CFG_SER:
            begin
                if ((q.ser_cnt == 6'h00) && !q.bus_wr)
                    n.fsm = pcr_pkg::PCR_CFG_APPLY;
            end
            pcr_pkg::PCR_CFG_APPLY:
            begin
                n.step = q.pll_sh[NW-1:0];
                n.pll_lock = 1'b1;
                n.fsm = pcr_pkg::PCR_CFG_IDLE;
            end
            default:
                n.fsm = pcr_pkg::PCR_CFG_IDLE;
        endcase

        // reconfiguration controller: register writes and serial shift into the pll
        if (q.bus_wr && (q.bus_addr == `PCR_RC_STEP))
            n.rc_step = q.bus_wdata;
        if (q.ser_cnt != 6'h00)
        begin
            n.pll_sh = {q.pll_sh[30:0], q.ser_sh[31]};
            n.ser_sh = {q.ser_sh[30:0], 1'b0};
            n.ser_cnt = q.ser_cnt - 6'h01;
        end
        else if (q.bus_wr && (q.bus_addr == `PCR_RC_START))
        begin
            n.ser_sh = q.rc_step;
            n.ser_cnt = `PCR_RC_BITS;
        end

        // loop controller: steer Mvid toward a half-full FIFO
        n.loop_cnt = (q.loop_cnt == LOOP_LAST) ? 16'h0000 : q.loop_cnt + 16'h0001;
        if ((q.loop_cnt == LOOP_LAST) && q.loop_en && q.running)
        begin
            if ((fill > FILL_MID) && (q.trim < `PCR_TRIM_MAX))
            begin
                n.trim = q.trim + 16'sd1;
                n.recalc = 1'b1;
            end
            else if ((fill < FILL_MID) && (q.trim > -`PCR_TRIM_MAX))
            begin
                n.trim = q.trim - 16'sd1;
                n.recalc = 1'b1;
            end
        end

        // read side starts once the pll runs and the FIFO is half full
        if (q.pll_lock && (fill >= FILL_MID))
            n.running = 1'b1;

        // timing generator on recovered clock rises
        n.rd_pend = 1'b0;
        if (!q.running)
        begin
            n.hcnt = '0;
            n.vcnt = '0;
            n.sync.hsync = q.msa[1].hsync_low;
            n.sync.vsync = q.msa[1].vsync_low;
            n.sync.data_enable_out = 1'b0;
            n.sync.second_field_flag = 1'b0;
        end
        else if (tick)
        begin
            hn = q.hcnt + 16'(PIXELS_PER_CLOCK);
            if (hn >= q.cfg.htotal)
            begin
                hn = '0;
                vn = q.vcnt + 16'h0001;
                if (vn >= q.cfg.vtotal)
                begin
                    vn = '0;
                    fld = q.cfg.interlaced && !q.sync.second_field_flag;
                end
            end
            de_n = ({1'b0, hn} >= {1'b0, q.cfg.hstart})
                && ({1'b0, hn} < ({1'b0, q.cfg.hstart} + {1'b0, q.cfg.hwidth}))
                && ({1'b0, vn} >= {1'b0, q.cfg.vstart})
                && ({1'b0, vn} < ({1'b0, q.cfg.vstart} + {1'b0, q.cfg.vheight}));
            n.hcnt = hn;
            n.vcnt = vn;
            n.sync.hsync = (hn < {1'b0, q.cfg.hsw}) ^ q.cfg.hsync_low;
            n.sync.vsync = (vn < {1'b0, q.cfg.vsw}) ^ q.cfg.vsync_low;
            n.sync.data_enable_out = de_n;
            n.sync.second_field_flag = fld;
            rd_en = de_n;
            n.rd_pend = de_n;
        end
        if (q.rd_pend)
            n.vid = rd_data;

        // register port
        n.rdata = 32'h0000_0000;
        if (reg_req.rd)
        begin
            case (reg_req.addr)
                `PCR_ADDR_CTRL:   n.rdata = 32'(q.loop_en) << `PCR_CTRL_LOOP_EN;
                `PCR_ADDR_STATUS: n.rdata = (32'(q.lock_ok) << `PCR_ST_LOCK)
                                          | (32'(q.pll_lock) << `PCR_ST_PLL_LOCK)
                                          | (32'(q.running) << `PCR_ST_RUNNING)
                                          | (32'(q.rst_out) << `PCR_ST_RESET_OUT)
                                          | (32'(fill) << `PCR_ST_FILL_LSB)
                                          | (32'(RXW) << `PCR_ST_RXW_LSB);
                `PCR_ADDR_MVID:   n.rdata = 32'(q.mvid_adj);
                `PCR_ADDR_STEP:   n.rdata = 32'(q.step);
                default:          n.rdata = 32'h0000_0000;
            endcase
        end
        if (reg_req.wr && (reg_req.addr == `PCR_ADDR_CTRL))
        begin
            n.loop_en = reg_req.wdata[`PCR_CTRL_LOOP_EN];
            if (reg_req.wdata[`PCR_CTRL_RESYNC])
                n.recalc = 1'b1;
        end

        // losing the sink lock idles the sequence, drops pll lock, running and trim (the step and FIFO are kept) and queues a fresh setup
        if (!lock_ok)
        begin
            n.fsm = pcr_pkg::PCR_CFG_IDLE;
            n.pll_lock = 1'b0;
            n.running = 1'b0;
            n.trim = '0;
            n.recalc = 1'b1;
        end
        n.rst_out = !(q.pll_lock && q.running && lock_ok);
    end

    // state register
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            q         <= '0;
            q.fsm     <= pcr_pkg::PCR_CFG_IDLE;
            q.loop_en <= 1'b1;
            q.rst_out <= 1'b1;
        end
        else
            q <= n;
    end

    // outputs straight from state
    assign reg_rdata                    = q.rdata;
    assign recovered_pixel_clock        = q.rclk;
    assign recovered_pixel_clock_double = q.clk2;
    assign vidout                       = q.vid;
    assign video_sync                   = q.sync;
    assign reset_out                    = q.rst_out;
    assign sink_video_lock_status       = q.lock_ok;

endmodule : pcr_core

// File: pcr_core_sva.sv
`timescale 1ns/1ps

module pcr_core_sva (
    // clock and reset
    input wire logic              clk,
    input wire logic              rstn,
    // sink side
    input wire logic [1:0]        sink_link_rate,
    input wire logic              sink_video_lock_in,
    input wire pcr_pkg::pcr_msa_t sink_msa,
    // recovered side
    input wire logic              recovered_pixel_clock,
    input wire logic              recovered_pixel_clock_double,
    input wire pcr_pkg::pcr_sync_t video_sync,
    input wire logic              reset_out,
    input wire logic              sink_video_lock_status
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    logic [2:0] nd_q;
    logic       seen_q;

    // double clock changes since the last pixel clock change
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            nd_q   <= 3'h0;
            seen_q <= 1'b0;
        end
        else if ($changed(recovered_pixel_clock))
        begin
            nd_q   <= 3'h0;
            seen_q <= 1'b1;
        end
        else
            nd_q <= nd_q + 3'($changed(recovered_pixel_clock_double));
    end

    // outputs held invalid, or held valid, for a few cycles
    sequence s_idle;
        reset_out[*3];
    endsequence
    sequence s_run;
        (!reset_out)[*2];
    endsequence
    // idle long enough for the synchronised attributes to reach the syncs
    sequence s_settled;
        reset_out[*5];
    endsequence

    AST_RATE_RSVD: assert property ((sink_link_rate == 2'h3)[*5] |-> !sink_video_lock_status)
        else $error("lock shown on reserved rate");
    AST_LOCK_DROP: assert property ((!sink_video_lock_in)[*5] |-> !sink_video_lock_status)
        else $error("lock kept without good video");
    AST_LOCK_SET: assert property ((sink_video_lock_in && sink_link_rate != 2'h3)[*5] |-> sink_video_lock_status)
        else $error("lock missing with good video");
    AST_INVALID: assert property ((!sink_video_lock_status)[*3] |-> reset_out)
        else $error("outputs claimed valid while unlocked");
    AST_DE_IDLE: assert property (s_idle |-> !video_sync.data_enable_out)
        else $error("data enable active while invalid");
    AST_SYNC_POL: assert property (s_settled |-> video_sync.hsync == $past(sink_msa.hsync_low, 3)
                                   && video_sync.vsync == $past(sink_msa.vsync_low, 3))
        else $error("idle sync level wrong");
    AST_FIELD_IDLE: assert property (s_idle |-> !video_sync.second_field_flag)
        else $error("second field flag while invalid");
    AST_SYNC_TICK: assert property (s_run ##0 $changed(video_sync) |-> $rose(recovered_pixel_clock))
        else $error("timing changed off a pixel clock rise");
    AST_CLK_RATIO: assert property ($changed(recovered_pixel_clock) && seen_q
                                    |-> nd_q + 3'($changed(recovered_pixel_clock_double)) == 3'h2)
        else $error("double clock not twice the pixel clock");
endmodule : pcr_core_sva

bind pcr_core pcr_core_sva u_sva (
    .clk(clk),
    .rstn(rstn),
    .sink_link_rate(sink_link_rate),
    .sink_video_lock_in(sink_video_lock_in),
    .sink_msa(sink_msa),
    .recovered_pixel_clock(recovered_pixel_clock),
    .recovered_pixel_clock_double(recovered_pixel_clock_double),
    .video_sync(video_sync),
    .reset_out(reset_out),
    .sink_video_lock_status(sink_video_lock_status)
);

// File: pcr_sink_model.sv
`timescale 1ns/1ps

module pcr_sink_model #(
    parameter int DW = 192
) (
    // trained and sending
    input wire logic     go,
    // video toward the core
    output logic          pin,
    output logic [DW-1:0] data,
    output logic          valid
);
    logic [15:0] cnt_q;

    // free running video clock, 125 ns
    initial
    begin
        pin = 1'b0;
        cnt_q = 16'h0;
        valid = 1'b0;
        data = '0;
        forever #62.5 pin = ~pin;
    end

    // counting words, inverted filler when idle
    always @(posedge pin)
    begin
        valid <= go;
        if (go)
        begin
            cnt_q <= cnt_q + 16'h1;
            data <= {(DW/16){cnt_q + 16'h1}};
        end
        else
            data <= ~data;
    end
endmodule : pcr_sink_model

// File: pcr_core_bench.sv
`timescale 1ns/1ps
`include "pcr_regs.svh"

module pcr_core_bench;
    logic clk, rstn, pin, valid, lock, go, rclk, rclk2, rst_out, lock_st;
    logic [1:0] rate;
    logic [191:0] data, vid, prev;
    logic [31:0] rdata, r, d;
    logic [23:0] m;
    pcr_pkg::pcr_reg_req_t req;
    pcr_pkg::pcr_msa_t msa;
    pcr_pkg::pcr_sync_t sync;
    int err_total, num_checks, cyc, nwords, nfield;

    pcr_core #(.LOOP_CYCLES(64)) dut (.clk(clk), .rstn(rstn), .reg_req(req), .reg_rdata(rdata),
        .sink_video_clock_pin(pin), .sink_video_data(data), .sink_video_valid(valid),
        .sink_video_lock_in(lock), .sink_link_rate(rate), .sink_msa(msa),
        .recovered_pixel_clock(rclk), .recovered_pixel_clock_double(rclk2), .vidout(vid),
        .video_sync(sync), .reset_out(rst_out), .sink_video_lock_status(lock_st));
    pcr_sink_model u_sink (.go(go), .pin(pin), .data(data), .valid(valid));

    // control clock
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_reg

    task automatic chk_bit(input logic got, input logic exp);
        chk_reg({31'h0, got}, {31'h0, exp});
    endtask : chk_bit

    task automatic final_report();
        $display("err_total=%0d num_checks=%0d", err_total, num_checks);
        if (err_total == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : final_report

    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge clk);
        req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        req <= '0;
    endtask : wr

    // read data lands in r
    task automatic rd(input logic [3:0] a);
        @(posedge clk);
        req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        req <= '0;
        #1 r = rdata;
    endtask : rd

    // poll one status bit, bounded
    task automatic wait_st(input int b);
        for (int n = 0; n < 300; n++)
        begin
            rd(`PCR_ADDR_STATUS);
            if (r[b] === 1'b1)
                break;
        end
        chk_bit(r[b], 1'b1);
    endtask : wait_st

    // drop the link, retune, bring it back
    task automatic sess(input logic [1:0] rt, input logic [23:0] mv, input logic en);
        @(posedge clk);
        lock <= 1'b0;
        go <= 1'b0;
        repeat (20) @(posedge clk);
        msa.mvid <= mv;
        rate <= rt;
        wr(`PCR_ADDR_CTRL, {31'h0, en});
        lock <= 1'b1;
        go <= 1'b1;
    endtask : sess

    // clock step for a rate and Mvid, period 10 ns, four pixels
    function automatic logic [31:0] exp_step(input logic [1:0] rt, input logic [23:0] mv);
        longint k, s;
        k = (longint'(10 * 4) << 24) * (rt == 2'h0 ? `PCR_SYM_MHZ_LOW : rt == 2'h1 ? `PCR_SYM_MHZ_HIGH
            : `PCR_SYM_MHZ_HIGH2) / (1000 * 4);
        s = mv * k / 32768;
        return (s > 64'h80_0000) ? 32'h80_0000 : s[31:0];
    endfunction : exp_step

    // words must arrive whole and in order
    always @(posedge clk)
    begin
        cyc++;
        if (sync.second_field_flag === 1'b1)
            nfield++;
        if (rstn && rst_out === 1'b0 && vid !== prev)
        begin
            chk_bit(vid === {12{vid[15:0]}} && vid[15:0] > prev[15:0], 1'b1);
            prev <= vid;
            nwords++;
        end
        if (cyc == 40000)
        begin
            err_total++;
            final_report();
        end
    end

    initial
    begin
        void'($urandom(22));
        rstn = 1'b0;
        req = '0;
        lock = 1'b0;
        go = 1'b0;
        rate = 2'h0;
        prev = '0;
        msa = '{mvid: 24'h0, nvid: 24'h8000, htotal: 16'h10, vtotal: 16'h4, hstart: 16'h2, vstart: 16'h0,
                hwidth: 16'hc, vheight: 16'h4, hsync_low: 1'($urandom), hsw: 15'h2, vsync_low: 1'($urandom),
                vsw: 15'h1, interlaced: 1'b1, spare: {$urandom, 8'h5a}};
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        rd(`PCR_ADDR_CTRL);
        chk_reg(r, 32'h1);
        rd(`PCR_ADDR_STATUS);
        chk_reg(r & 32'h00ff_ffff, 32'h0028_0008);
        wr(4'h2, $urandom);
        rd(4'h2);
        chk_reg(r, 32'h0);
        // every rate code with the loop held off
        for (int i = 0; i < 4; i++)
        begin
            // small enough that no rate hits the step ceiling
            m = 24'd1000 + 24'($urandom % 1000);
            sess(i[1:0], m, 1'b0);
            if (i == 3)
            begin
                repeat (30) @(posedge clk);
                rd(`PCR_ADDR_STATUS);
                chk_bit(r[`PCR_ST_LOCK], 1'b0);
            end
            else
            begin
                wait_st(`PCR_ST_PLL_LOCK);
                rd(`PCR_ADDR_MVID);
                chk_reg(r, {8'h0, m});
                rd(`PCR_ADDR_STEP);
                d = r - exp_step(i[1:0], m);
                chk_bit(d + 32'h2 <= 32'h4, 1'b1);
            end
        end
        // slow then fast reading, loop on
        sess(2'h0, 24'd8000, 1'b1);
        wait_st(`PCR_ST_RUNNING);
        repeat (2) @(posedge clk);
        chk_bit(rst_out, 1'b0);
        repeat (3000) @(posedge clk);
        rd(`PCR_ADDR_MVID);
        chk_bit(r > 32'd8000, 1'b1);
        sess(2'h0, 24'd9300, 1'b1);
        wait_st(`PCR_ST_RUNNING);
        repeat (3000) @(posedge clk);
        rd(`PCR_ADDR_MVID);
        chk_bit(r < 32'd9300, 1'b1);
        chk_bit(nfield > 0, 1'b1);
        chk_bit(nwords > 20, 1'b1);
        final_report();
    end
endmodule : pcr_core_bench
